// *** rtl/gpcfg_pkg.sv ***
// Constants for the six-port GPIO configuration block
package gpcfg_pkg;
  localparam int unsigned PORTS   = 6;
  localparam int unsigned PIN_W   = 48;
  localparam int unsigned VECS    = 4;
  localparam int unsigned REGS_PP = 3;
  localparam int unsigned PREGS   = 18;
  // Register indices, byte address is four times the index
  localparam logic [4:0] IDX_PORT_A_DATA = 5'h00;
  localparam logic [4:0] IDX_PORT_A_DIR  = 5'h01;
  localparam logic [4:0] IDX_PORT_A_OPT  = 5'h02;
  localparam logic [4:0] IDX_PORT_B_DATA = 5'h03;
  localparam logic [4:0] IDX_PORT_B_DIR  = 5'h04;
  localparam logic [4:0] IDX_PORT_B_OPT  = 5'h05;
  localparam logic [4:0] IDX_PORT_C_DATA = 5'h06;
  localparam logic [4:0] IDX_PORT_C_DIR  = 5'h07;
  localparam logic [4:0] IDX_PORT_C_OPT  = 5'h08;
  localparam logic [4:0] IDX_PORT_D_DATA = 5'h09;
  localparam logic [4:0] IDX_PORT_D_DIR  = 5'h0a;
  localparam logic [4:0] IDX_PORT_D_OPT  = 5'h0b;
  localparam logic [4:0] IDX_PORT_E_DATA = 5'h0c;
  localparam logic [4:0] IDX_PORT_E_DIR  = 5'h0d;
  localparam logic [4:0] IDX_PORT_E_OPT  = 5'h0e;
  localparam logic [4:0] IDX_PORT_F_DATA = 5'h0f;
  localparam logic [4:0] IDX_PORT_F_DIR  = 5'h10;
  localparam logic [4:0] IDX_PORT_F_OPT  = 5'h11;
  localparam logic [4:0] IDX_IRQ_STAT    = 5'h12;
  localparam logic [4:0] IDX_IRQ_MASK    = 5'h13;
  localparam logic [4:0] IDX_IRQ_SENSE   = 5'h14;
  // Reset values
  localparam logic [7:0] PORT_RST  = 8'h00;
  localparam logic [3:0] STAT_RST  = 4'h0;
  localparam logic [3:0] MASK_RST  = 4'h0;
  localparam logic [7:0] SENSE_RST = 8'h00;
  // Pin classes, bit 8*port+pin, port A lowest
  localparam logic [47:0] IRQ_PU_PINS = 48'h0300_0000_7707;
  localparam logic [47:0] IRQ_FL_PINS = 48'h0400_0000_8808;
  localparam logic [47:0] TOD_PINS    = 48'h0000_0000_00c0;
  localparam logic [47:0] PUP_PINS    = 48'h0004_0000_0000;
  localparam logic [7:0]  A_OPT_WMASK = 8'h3f;
  // Pins sharing each interrupt vector
  localparam logic [47:0] VEC0_PINS = 48'h0000_0000_000f;
  localparam logic [47:0] VEC1_PINS = 48'h0700_0000_0000;
  localparam logic [47:0] VEC2_PINS = 48'h0000_0000_0f00;
  localparam logic [47:0] VEC3_PINS = 48'h0000_0000_f000;
  // Sensitivity codes and AXI response codes
  localparam logic [1:0] SNS_FALL_LOW = 2'h0;
  localparam logic [1:0] SNS_RISE     = 2'h1;
  localparam logic [1:0] SNS_FALL     = 2'h2;
  localparam logic [1:0] SNS_BOTH     = 2'h3;
  localparam logic [1:0] RESP_OKAY    = 2'h0;
  localparam logic [1:0] RESP_SLVERR  = 2'h2;
endpackage : gpcfg_pkg

// *** rtl/gpcfg_top.sv ***
// Six-port GPIO configuration block with AXI4-Lite registers
//
// Behaviour
// [RULE1]: Standard pins: dir/opt 00 float, 01 pull-up, 10 open-drain, 11 push-pull.
// [RULE2]: Pull-up interrupt pins: dir 0 opt 1 is pull-up input with interrupt.
// [RULE3]: Floating interrupt pins: dir 0 opt 1 floating interrupt, 00 floating.
// [RULE4]: Port A 7:6 has no option; dir 1 is open-drain, never high.
// [RULE5]: Port E bit 2: dir 0 pull-up input; dir 1 opt selects output kind.
// [RULE6]: Port E bit 2 pull-up stays on in every configuration.
// [RULE7]: Data, direction, option per port at consecutive indices, all reset zero.
// [RULE8]: Bit n of each port register belongs to pin n.
// [RULE9]: Input pin: read returns pin level; write updates latch only.
// [RULE10]: Output pin: latch drives pin; read returns latch.
// [RULE11]: Interrupt pins per vector detected by sensitivity, ORed, cleared on fetch.
// [RULE12]: Pin levels are synchronised before reads and interrupt detection.
//
// Implementation choice: the AXI4-Lite interface to the registers.

`timescale 1ns/1ps

module gpcfg_top (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [47:0] pin_in,
  output logic [47:0]      pin_out,
  output logic [47:0]      pin_oe,
  output logic [47:0]      pin_pullup,
  input  wire logic [3:0]  vector_fetch,
  output logic             irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic [4:0] reg_index(input int p, input int k);
    reg_index = 5'((p * gpcfg_pkg::REGS_PP) + k);
  endfunction : reg_index

  function automatic logic [47:0] vec_pins(input int v);
    case (v)
      0:       vec_pins = gpcfg_pkg::VEC0_PINS;
      1:       vec_pins = gpcfg_pkg::VEC1_PINS;
      2:       vec_pins = gpcfg_pkg::VEC2_PINS;
      default: vec_pins = gpcfg_pkg::VEC3_PINS;
    endcase
  endfunction : vec_pins

  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = !a[7] && (a[6:2] <= gpcfg_pkg::IDX_IRQ_SENSE);
  endfunction : addr_ok

  ////////////////////////////////////////////////////////////////////////////
  // State

  logic [7:0]  regs_ff [gpcfg_pkg::PREGS];
  logic [7:0]  nxt_regs [gpcfg_pkg::PREGS];
  logic [3:0]  stat_ff, nxt_stat;
  logic [3:0]  mask_ff, nxt_mask;
  logic [7:0]  sense_ff, nxt_sense;
  logic        aw_have_ff, nxt_aw_have;
  logic        w_have_ff, nxt_w_have;
  logic [7:0]  awaddr_ff, nxt_awaddr;
  logic [7:0]  wdata_ff, nxt_wdata;
  logic        wstrb0_ff, nxt_wstrb0;
  logic        awready_ff, nxt_awready;
  logic        wready_ff, nxt_wready;
  logic        bvalid_ff, nxt_bvalid;
  logic [1:0]  bresp_ff, nxt_bresp;
  logic        arready_ff, nxt_arready;
  logic        rvalid_ff, nxt_rvalid;
  logic [31:0] rdata_ff, nxt_rdata;
  logic [1:0]  rresp_ff, nxt_rresp;
  logic        irq_ff, nxt_irq;
  logic [47:0] sync1_ff, sync2_ff, sync3_ff;
  logic [47:0] filt_ff, nxt_filt;
  logic [47:0] prev_ff;
  logic [47:0] out_ff, nxt_out;
  logic [47:0] oe_ff, nxt_oe;
  logic [47:0] pup_ff, nxt_pup;
  logic [47:0] irq_en;
  logic [3:0]  vec_ev;
  logic        do_write;
  logic [4:0]  widx, ridx;

  assign s_axi_awready = awready_ff;
  assign s_axi_wready  = wready_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rdata   = rdata_ff;
  assign s_axi_rresp   = rresp_ff;
  assign pin_out       = out_ff;
  assign pin_oe        = oe_ff;
  assign pin_pullup    = pup_ff;
  assign irq           = irq_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Bus, registers and interrupt status

  assign widx     = awaddr_ff[6:2];
  assign ridx     = s_axi_araddr[6:2];
  assign do_write = aw_have_ff && w_have_ff && !bvalid_ff;

  always_comb begin : bus_next
    logic [7:0] rv;
    logic [3:0] w1c;
    rv          = 8'h00;
    w1c         = 4'h0;
    nxt_regs    = regs_ff;
    nxt_mask    = mask_ff;
    nxt_sense   = sense_ff;
    nxt_aw_have = aw_have_ff;
    nxt_w_have  = w_have_ff;
    nxt_awaddr  = awaddr_ff;
    nxt_wdata   = wdata_ff;
    nxt_wstrb0  = wstrb0_ff;
    nxt_bvalid  = bvalid_ff;
    nxt_bresp   = bresp_ff;
    nxt_rvalid  = rvalid_ff;
    nxt_rdata   = rdata_ff;
    nxt_rresp   = rresp_ff;
    if (s_axi_awvalid && awready_ff) begin
      nxt_aw_have = 1'b1;
      nxt_awaddr  = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_ff) begin
      nxt_w_have = 1'b1;
      nxt_wdata  = s_axi_wdata[7:0];
      nxt_wstrb0 = s_axi_wstrb[0];
    end
    if (bvalid_ff && s_axi_bready) begin
      nxt_bvalid = 1'b0;
    end
    if (do_write) begin
      nxt_aw_have = 1'b0;
      nxt_w_have  = 1'b0;
      nxt_bvalid  = 1'b1;
      nxt_bresp   = addr_ok(awaddr_ff) ? gpcfg_pkg::RESP_OKAY
                                       : gpcfg_pkg::RESP_SLVERR;
      if (addr_ok(awaddr_ff) && wstrb0_ff) begin
        if (widx < gpcfg_pkg::IDX_IRQ_STAT) begin
          // Write only touches the latch, never the pin directly
          nxt_regs[widx] = wdata_ff; // [RULE7] [RULE9]
          if (widx == gpcfg_pkg::IDX_PORT_A_OPT) begin
            nxt_regs[widx] = wdata_ff & gpcfg_pkg::A_OPT_WMASK; // [RULE4]
          end
        end else if (widx == gpcfg_pkg::IDX_IRQ_STAT) begin
          w1c = wdata_ff[3:0];
        end else if (widx == gpcfg_pkg::IDX_IRQ_MASK) begin
          nxt_mask = wdata_ff[3:0];
        end else begin
          nxt_sense = wdata_ff;
        end
      end
    end
    nxt_awready = !nxt_aw_have;
    nxt_wready  = !nxt_w_have;
    if (rvalid_ff && s_axi_rready) begin
      nxt_rvalid = 1'b0;
    end
    if (s_axi_arvalid && arready_ff) begin
      if (ridx < gpcfg_pkg::IDX_IRQ_STAT) begin
        rv = regs_ff[ridx];
      end else if (ridx == gpcfg_pkg::IDX_IRQ_STAT) begin
        rv = {4'h0, stat_ff};
      end else if (ridx == gpcfg_pkg::IDX_IRQ_MASK) begin
        rv = {4'h0, mask_ff};
      end else begin
        rv = sense_ff;
      end
      for (int p = 0; p < gpcfg_pkg::PORTS; p++) begin
        if (ridx == reg_index(p, 0)) begin
          // Inputs show the pin, outputs the latch
          rv = (regs_ff[reg_index(p, 1)] & regs_ff[ridx]) |
               (~regs_ff[reg_index(p, 1)] & filt_ff[p*8 +: 8]); // [RULE8] [RULE9] [RULE10]
        end
      end
      nxt_rvalid = 1'b1;
      nxt_rdata  = addr_ok(s_axi_araddr) ? {24'h000000, rv} : 32'h00000000;
      nxt_rresp  = addr_ok(s_axi_araddr) ? gpcfg_pkg::RESP_OKAY
                                         : gpcfg_pkg::RESP_SLVERR;
    end
    nxt_arready = !nxt_rvalid;
    // New event beats a simultaneous clear
    nxt_stat = (stat_ff & ~(w1c | vector_fetch)) | vec_ev; // [RULE11]
    nxt_irq  = |(nxt_stat & nxt_mask);
  end

  always_ff @(posedge aclk) begin : bus_regs
    if (!aresetn) begin
      for (int r = 0; r < gpcfg_pkg::PREGS; r++) begin
        regs_ff[r] <= gpcfg_pkg::PORT_RST; // [RULE7]
      end
      stat_ff    <= gpcfg_pkg::STAT_RST;
      mask_ff    <= gpcfg_pkg::MASK_RST;
      sense_ff   <= gpcfg_pkg::SENSE_RST;
      aw_have_ff <= 1'b0;
      w_have_ff  <= 1'b0;
      awaddr_ff  <= 8'h00;
      wdata_ff   <= 8'h00;
      wstrb0_ff  <= 1'b0;
      awready_ff <= 1'b0;
      wready_ff  <= 1'b0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= gpcfg_pkg::RESP_OKAY;
      arready_ff <= 1'b0;
      rvalid_ff  <= 1'b0;
      rdata_ff   <= 32'h00000000;
      rresp_ff   <= gpcfg_pkg::RESP_OKAY;
      irq_ff     <= 1'b0;
    end else if (ce) begin
      regs_ff    <= nxt_regs;
      stat_ff    <= nxt_stat;
      mask_ff    <= nxt_mask;
      sense_ff   <= nxt_sense;
      aw_have_ff <= nxt_aw_have;
      w_have_ff  <= nxt_w_have;
      awaddr_ff  <= nxt_awaddr;
      wdata_ff   <= nxt_wdata;
      wstrb0_ff  <= nxt_wstrb0;
      awready_ff <= nxt_awready;
      wready_ff  <= nxt_wready;
      bvalid_ff  <= nxt_bvalid;
      bresp_ff   <= nxt_bresp;
      arready_ff <= nxt_arready;
      rvalid_ff  <= nxt_rvalid;
      rdata_ff   <= nxt_rdata;
      rresp_ff   <= nxt_rresp;
      irq_ff     <= nxt_irq;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin modes, synchroniser and edge detection

  always_comb begin : pin_next
    logic dir;
    logic opt;
    logic lat;
    logic pp;
    logic [47:0] cond;
    logic [1:0]  sns;
    dir  = 1'b0;
    opt  = 1'b0;
    lat  = 1'b0;
    pp   = 1'b0;
    cond = 48'h0;
    sns  = 2'h0;
    nxt_out = 48'h0;
    nxt_oe  = 48'h0;
    nxt_pup = 48'h0;
    irq_en  = 48'h0;
    for (int p = 0; p < gpcfg_pkg::PORTS; p++) begin
      for (int n = 0; n < 8; n++) begin
        lat = regs_ff[reg_index(p, 0)][n]; // [RULE8]
        dir = regs_ff[reg_index(p, 1)][n];
        opt = regs_ff[reg_index(p, 2)][n];
        // True open-drain pins ignore the option bit
        pp  = opt && !gpcfg_pkg::TOD_PINS[p*8+n]; // [RULE4]
        nxt_out[p*8+n] = dir && pp && lat; // [RULE1] [RULE10]
        nxt_oe[p*8+n]  = dir && (pp || !lat); // [RULE1] [RULE5]
        nxt_pup[p*8+n] = gpcfg_pkg::PUP_PINS[p*8+n] ||
                         (!dir && opt && !gpcfg_pkg::IRQ_FL_PINS[p*8+n]); // [RULE1] [RULE3] [RULE6]
        irq_en[p*8+n]  = !dir && opt &&
                         (gpcfg_pkg::IRQ_PU_PINS[p*8+n] ||
                          gpcfg_pkg::IRQ_FL_PINS[p*8+n]); // [RULE2] [RULE3]
      end
    end
    for (int v = 0; v < gpcfg_pkg::VECS; v++) begin
      sns = sense_ff[v*2 +: 2];
      case (sns)
        gpcfg_pkg::SNS_FALL_LOW: cond = ~filt_ff;
        gpcfg_pkg::SNS_RISE:     cond = filt_ff & ~prev_ff;
        gpcfg_pkg::SNS_FALL:     cond = ~filt_ff & prev_ff;
        gpcfg_pkg::SNS_BOTH:     cond = filt_ff ^ prev_ff;
        default:                 cond = 48'h0;
      endcase
      vec_ev[v] = |(cond & irq_en & vec_pins(v)); // [RULE11]
    end
    // Accept a new level once the last two stages agree
    nxt_filt = (~(sync2_ff ^ sync3_ff) & sync3_ff) |
               ((sync2_ff ^ sync3_ff) & filt_ff); // [RULE12]
  end

  always_ff @(posedge aclk) begin : pin_regs
    if (!aresetn) begin
      sync1_ff <= 48'h0;
      sync2_ff <= 48'h0;
      sync3_ff <= 48'h0;
      filt_ff  <= 48'h0;
      prev_ff  <= 48'h0;
      out_ff   <= 48'h0;
      oe_ff    <= 48'h0;
      pup_ff   <= gpcfg_pkg::PUP_PINS; // [RULE6]
    end else if (ce) begin
      sync1_ff <= pin_in; // [RULE12]
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
      filt_ff  <= nxt_filt;
      prev_ff  <= filt_ff;
      out_ff   <= nxt_out;
      oe_ff    <= nxt_oe;
      pup_ff   <= nxt_pup;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  property p_std_pushpull;
    @(posedge aclk) disable iff (!aresetn)
      ce && regs_ff[7][0] && regs_ff[8][0] |=> pin_oe[16] && pin_out[16] == $past(regs_ff[6][0]);
  endproperty
  a_std_pushpull: assert property (p_std_pushpull) // [RULE1]
    else $error("push-pull pin not driving latch");

  property p_std_opendrain;
    @(posedge aclk) disable iff (!aresetn)
      ce && regs_ff[10][0] && !regs_ff[11][0] |=> !pin_out[24] && pin_oe[24] == !$past(regs_ff[9][0]);
  endproperty
  a_std_opendrain: assert property (p_std_opendrain) // [RULE1]
    else $error("open-drain pin drives wrong");

  property p_pu_irq;
    @(posedge aclk) disable iff (!aresetn)
      ce && !regs_ff[1][0] && regs_ff[2][0] |-> irq_en[0] ##1 pin_pullup[0] && !pin_oe[0];
  endproperty
  a_pu_irq: assert property (p_pu_irq) // [RULE2]
    else $error("pull-up interrupt input wrong");

  property p_fl_irq;
    @(posedge aclk) disable iff (!aresetn)
      ce && !regs_ff[1][3] |-> irq_en[3] == regs_ff[2][3] ##1 !pin_pullup[3];
  endproperty
  a_fl_irq: assert property (p_fl_irq) // [RULE3]
    else $error("floating interrupt input wrong");

  property p_tod_never_high;
    @(posedge aclk) disable iff (!aresetn)
      !pin_out[7] && !pin_out[6] && regs_ff[2][7:6] == 2'b00;
  endproperty
  a_tod_never_high: assert property (p_tod_never_high) // [RULE4]
    else $error("true open-drain pin driven high");

  property p_pe2_input;
    @(posedge aclk) disable iff (!aresetn)
      ce && !regs_ff[13][2] |=> !pin_oe[34];
  endproperty
  a_pe2_input: assert property (p_pe2_input) // [RULE5]
    else $error("port E bit 2 drives in input mode");

  property p_pe2_pullup;
    @(posedge aclk) disable iff (!aresetn) pin_pullup[34];
  endproperty
  a_pe2_pullup: assert property (p_pe2_pullup) // [RULE6]
    else $error("port E bit 2 pull-up off");

  property p_reset_zero;
    @(posedge aclk) !aresetn |=> regs_ff[0] == 8'h00 && regs_ff[17] == 8'h00 && !irq;
  endproperty
  a_reset_zero: assert property (p_reset_zero) // [RULE7]
    else $error("register not cleared by reset");

  property p_irq_set;
    @(posedge aclk) disable iff (!aresetn)
      ce && vec_ev[0] |=> stat_ff[0];
  endproperty
  a_irq_set: assert property (p_irq_set) // [RULE11]
    else $error("interrupt event lost");

  property p_filter;
    @(posedge aclk) disable iff (!aresetn) $past(aresetn) && $changed(filt_ff) |->
      ((filt_ff ^ $past(filt_ff)) & ($past(sync2_ff) ^ $past(sync3_ff))) == 48'h0;
  endproperty
  a_filter: assert property (p_filter) // [RULE12]
    else $error("filtered level changed without agreement");

  c_irq: cover property (@(posedge aclk) disable iff (!aresetn) $rose(irq));
  c_write: cover property (@(posedge aclk) disable iff (!aresetn) do_write ##1 s_axi_bvalid);
  c_read: cover property (@(posedge aclk) disable iff (!aresetn) s_axi_rvalid && s_axi_rready);

endmodule : gpcfg_top

// *** dv/gpcfg_pin_model.sv ***
// Board-side model of the 48 port pins
`timescale 1ns/1ps

module gpcfg_pin_model (
  input  wire logic        aclk,
  input  wire logic [47:0] pin_out,
  input  wire logic [47:0] pin_oe,
  input  wire logic [47:0] pin_pullup,
  input  wire logic [47:0] ext_en,
  input  wire logic [47:0] ext_val,
  output logic      [47:0] pin_in
);
  logic [47:0] flt_ff = 48'h0;
  logic [47:0] nxt_flt;

  // Undriven pads wander every cycle
  always_comb nxt_flt = ~flt_ff;
  always_ff @(posedge aclk) flt_ff <= nxt_flt;

  // Block drive wins, then board drive, then pull-up
  assign pin_in = (pin_oe & pin_out)
                | (~pin_oe & ext_en & ext_val)
                | (~pin_oe & ~ext_en & (pin_pullup | flt_ff));
endmodule : gpcfg_pin_model

// *** dv/gpio_port_configuration_test.sv ***
// Register-level testbench of the GPIO configuration block
`timescale 1ns/1ps

module gpio_port_configuration_test;
  logic        aclk, aresetn, ce, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, irq;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb, vector_fetch;
  logic [1:0]  bresp, rresp;
  logic [47:0] pin_in, pin_out, pin_oe, pin_pullup, ext_en, ext_val;
  logic [7:0]  shd [18];
  int          n_errors, compares;

  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  gpcfg_top u_dut (
    .aclk(aclk), .aresetn(aresetn), .ce(ce),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup),
    .vector_fetch(vector_fetch), .irq(irq)
  );

  gpcfg_pin_model u_pins (
    .aclk(aclk), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup),
    .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in)
  );

  //////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : give_verdict

  task automatic check(input string what, input logic [47:0] seen, input logic [47:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wait_tmo(input int n);
    if (n >= 100) begin
      n_errors++;
      $display("mismatch handshake expected answer seen none");
      give_verdict();
    end
  endtask : wait_tmo

  task automatic reg_wr(input logic [4:0] idx, input logic [7:0] val,
                        input logic [1:0] er = gpcfg_pkg::RESP_OKAY);
    int n;
    @(posedge aclk);
    awaddr  <= {1'b0, idx, 2'b00};
    awvalid <= 1'b1;
    wdata   <= {24'h0, val};
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    wait_tmo(n);
    bready <= 1'b0;
    check("bresp", 48'(bresp), 48'(er));
    if (idx < 5'd18) shd[idx] = (idx == 5'd2) ? (val & gpcfg_pkg::A_OPT_WMASK) : val;
  endtask : reg_wr

  task automatic reg_rd(input logic [4:0] idx, input logic [7:0] ev,
                        input logic [1:0] er = gpcfg_pkg::RESP_OKAY);
    int n;
    @(posedge aclk);
    araddr  <= {1'b0, idx, 2'b00};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    wait_tmo(n);
    rready <= 1'b0;
    check($sformatf("reg %0d", idx), 48'(rdata), 48'(ev));
    check("rresp", 48'(rresp), 48'(er));
  endtask : reg_rd

  // Expected pad controls from the shadow of every port register
  task automatic check_pins();
    logic [47:0] eo, ev, ep;
    logic        d, o, q;
    repeat (2) @(posedge aclk);
    for (int i = 0; i < 48; i++) begin
      q = shd[3*(i/8)][i%8];
      d = shd[3*(i/8)+1][i%8];
      o = shd[3*(i/8)+2][i%8];
      eo[i] = gpcfg_pkg::TOD_PINS[i] ? (d & ~q) : (d & (o | ~q));
      ev[i] = gpcfg_pkg::TOD_PINS[i] ? 1'b0 : (d & o & q);
      ep[i] = gpcfg_pkg::PUP_PINS[i] | (~d & o & ~gpcfg_pkg::IRQ_FL_PINS[i]
              & ~gpcfg_pkg::TOD_PINS[i]);
    end
    check("pin_oe", pin_oe, eo);
    check("pin_out", pin_out, ev);
    check("pin_pullup", pin_pullup, ep);
  endtask : check_pins

  task automatic pin_edge(input int b, input logic v, input logic es, input logic ei,
                          input logic clr);
    ext_val[b] <= v;
    repeat (10) @(posedge aclk);
    reg_rd(gpcfg_pkg::IDX_IRQ_STAT, {7'h0, es});
    check("irq", 48'(irq), 48'(ei));
    if (clr) reg_wr(gpcfg_pkg::IDX_IRQ_STAT, 8'h01);
  endtask : pin_edge

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'h1;
    ce = 1'b1;
    vector_fetch = 4'h0;
    ext_en = 48'h0;
    ext_val = 48'h0;
    aresetn = 1'b0;
    n_errors = 0;
    compares = 0;
    foreach (shd[i]) shd[i] = 8'h00;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    // Data reads of input pins show the pad, so the pulled-up pin reads high
    for (int i = 0; i < 18; i++) begin
      reg_rd(5'(i), (i % 3 == 0) ? gpcfg_pkg::PUP_PINS[8*(i/3) +: 8] : 8'h00);
    end
    check_pins();
    reg_rd(5'h15, 8'h00, gpcfg_pkg::RESP_SLVERR);
    reg_wr(5'h15, 8'hff, gpcfg_pkg::RESP_SLVERR);
    // Two modes per pin, every mode on each pin class except port E bit 2, both latch levels
    for (int k = 0; k < 4; k++) begin
      for (int p = 0; p < 6; p++) begin
        reg_wr(5'(3*p), k[0] ? 8'ha5 : 8'h5a);
        reg_wr(5'(3*p+1), k[1] ? 8'hc3 : 8'h3c);
        reg_wr(5'(3*p+2), k[1] ? 8'h69 : 8'h96);
      end
      check_pins();
    end
    for (int i = 0; i < 18; i++) if (i % 3 != 0) reg_rd(5'(i), shd[i]);
    // Input reads on port D
    reg_wr(5'd10, 8'h00);
    reg_wr(5'd11, 8'h00);
    ext_en[31:24] <= 8'hff;
    ext_val[31:24] <= 8'h3c;
    reg_wr(5'd9, 8'hff);
    check_pins();
    repeat (8) @(posedge aclk);
    reg_rd(5'd9, 8'h3c);
    // Clock enable low freezes the synchroniser, so the read shows the old level
    ce <= 1'b0;
    ext_val[31:24] <= 8'hc3;
    repeat (8) @(posedge aclk);
    ce <= 1'b1;
    reg_rd(5'd9, 8'h3c);
    ext_en[31:24] <= 8'h00;
    reg_wr(5'd10, 8'hff);
    reg_wr(5'd11, 8'hff);
    check_pins();
    reg_rd(5'd9, 8'hff);
    reg_wr(5'd11, 8'h00);
    reg_wr(5'd9, 8'h0f);
    check_pins();
    reg_rd(5'd9, 8'h0f);
    // Interrupts on vector 0, every sensitivity code
    reg_wr(5'd1, 8'h00);
    reg_wr(5'd5, 8'h00);
    ext_en[3:0] <= 4'hf;
    ext_val[3:0] <= 4'h0;
    reg_wr(5'd2, 8'h09);
    reg_wr(gpcfg_pkg::IDX_IRQ_MASK, 8'h01);
    for (int c = 0; c < 4; c++) begin
      reg_wr(gpcfg_pkg::IDX_IRQ_SENSE, 8'(c));
      reg_wr(gpcfg_pkg::IDX_IRQ_STAT, 8'h0f);
      // Low-level code keeps requesting while pin 3 stays low
      pin_edge(0, 1'b1, c != 2, c != 2, 1'b1);
      pin_edge(0, 1'b0, c != 1, c != 1, 1'b1);
    end
    reg_wr(gpcfg_pkg::IDX_IRQ_SENSE, 8'h01);
    reg_wr(gpcfg_pkg::IDX_IRQ_STAT, 8'h0f);
    reg_wr(gpcfg_pkg::IDX_IRQ_MASK, 8'h00);
    pin_edge(0, 1'b1, 1'b1, 1'b0, 1'b1);
    reg_wr(gpcfg_pkg::IDX_IRQ_MASK, 8'h01);
    pin_edge(3, 1'b1, 1'b1, 1'b1, 1'b0);
    vector_fetch <= 4'h1;
    @(posedge aclk);
    vector_fetch <= 4'h0;
    repeat (3) @(posedge aclk);
    check("irq", 48'(irq), 48'h0);
    reg_rd(gpcfg_pkg::IDX_IRQ_STAT, 8'h00);
    give_verdict();
  end
endmodule : gpio_port_configuration_test
